// >>> design/mem_pkg.sv
`default_nettype none
package mem_pkg;
   localparam int ADDR_W = 16;
   localparam int DATA_W = 8;
   localparam int LOCAL_W = 13;
   localparam int NUM_MASTERS = 3;
   localparam int NUM_SECTIONS = 4;
   localparam int CNT_W = 2;

   // Master indices, lowest index wins arbitration
   typedef enum logic [1:0] {MST_CPU, MST_DMA_WR, MST_DMA_RD} master_e;
   localparam int CPU_IDX = 0;
   localparam int DMA_WR_IDX = 1;
   localparam int DMA_RD_IDX = 2;

   // Data space map, one section per memory set
   localparam logic [ADDR_W-1:0] IO_BASE = 16'h0000;
   localparam logic [ADDR_W-1:0] EEPROM_BASE = 16'h1000;
   localparam logic [ADDR_W-1:0] SRAM0_BASE = 16'h2000;
   localparam logic [ADDR_W-1:0] SRAM1_BASE = 16'h4000;
   localparam logic [ADDR_W-1:0] MAP_END = 16'h6000;
   localparam int SEC_IO = 0;
   localparam int SEC_SRAM0 = 1;
   localparam int SEC_SRAM1 = 2;
   localparam int SEC_EEPROM = 3;

   // Per-section timing, indexed by section number
   localparam int READ_LAT [NUM_SECTIONS] = '{1, 2, 2, 3};
   localparam int BURST_GAP [NUM_SECTIONS] = '{1, 1, 1, 2};
   localparam int DEPTH_LOG [NUM_SECTIONS] = '{12, 13, 13, 11};
   localparam logic [ADDR_W-1:0] SEC_BASE [NUM_SECTIONS] =
      '{IO_BASE, SRAM0_BASE, SRAM1_BASE, EEPROM_BASE};

   // Flash paging through the Z pointer
   localparam int Z_W = 18;
   localparam int FLASH_WORD_INDEX_LSB = 1;
   localparam int FLASH_WORD_INDEX_MSB = 8;
   localparam int FLASH_PAGE_INDEX_LSB = 9;
   localparam int FLASH_PAGE_INDEX_MSB = 17;
   localparam int FLASH_PAGE_WORDS = 256;
   localparam int APP_PAGES = 384;
   localparam int BOOT_PAGES = 16;
   localparam logic [8:0] FLASH_PAGES = 9'(APP_PAGES + BOOT_PAGES);

   // EEPROM paging through the NVM address register
   localparam int NVM_ADDR_W = 11;
   localparam int EBYTE_LSB = 0;
   localparam int EBYTE_MSB = 4;
   localparam int EPAGE_LSB = 5;
   localparam int EPAGE_MSB = 10;
   localparam int EE_PAGE_BYTES = 32;
endpackage
`default_nettype wire

// >>> design/sect_if.sv
`default_nettype none
interface sect_if;
   import mem_pkg::*;
   logic req;
   logic we;
   logic hold;
   logic [LOCAL_W-1:0] addr;
   logic [DATA_W-1:0] wdata;
   logic accept;
   logic busy;
   logic rvalid;
   logic [DATA_W-1:0] rdata;
   modport arb (output req, we, hold, addr, wdata,
                input accept, busy, rvalid, rdata);
   modport mem (input req, we, hold, addr, wdata,
                output accept, busy, rvalid, rdata);
endinterface
`default_nettype wire

// >>> design/section_port.sv
`default_nettype none
module section_port
   import mem_pkg::*;
#(
   parameter int DEPTH_BITS = 12,
   parameter int LAT = 2,
   parameter int GAP = 1
) (
   input wire logic sys_clk, // CPU clock
   input wire logic arst_n, // Async reset, low
   sect_if.mem bus // Arbitrated section port
);
   logic [DATA_W-1:0] mem [2**DEPTH_BITS];
   logic [DEPTH_BITS-1:0] ptr;
   logic [CNT_W-1:0] cnt;
   logic busy;
   logic [DEPTH_BITS-1:0] reqAddr;

   assign reqAddr = bus.addr[DEPTH_BITS-1:0];
   assign bus.accept = bus.req && !busy;
   assign bus.busy = busy;

   always_ff @(posedge sys_clk)
   begin
      if (bus.accept && bus.we)
      begin
         mem[reqAddr] <= bus.wdata;
      end
   end

   always_ff @(posedge sys_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         busy <= 1'b0;
         cnt <= '0;
         ptr <= '0;
         bus.rvalid <= 1'b0;
         bus.rdata <= '0;
      end
      else
      begin
         bus.rvalid <= 1'b0;
         if (bus.accept && !bus.we)
         begin
            if (LAT == 1)
            begin
               bus.rdata <= mem[reqAddr];
               bus.rvalid <= 1'b1;
            end
            else
            begin
               busy <= 1'b1;
               ptr <= reqAddr;
               cnt <= CNT_W'(LAT - 2);
            end
         end
         else if (busy)
         begin
            if (cnt == '0)
            begin
               bus.rdata <= mem[ptr];
               bus.rvalid <= 1'b1;
               // Burst goes on while owner keeps asking
               if (bus.hold)
               begin
                  ptr <= ptr + 1'b1;
                  cnt <= CNT_W'(GAP - 1);
               end
               else
               begin
                  busy <= 1'b0;
               end
            end
            else
            begin
               cnt <= cnt - 1'b1;
            end
         end
      end
   end
endmodule // section_port
`default_nettype wire

// >>> design/mem_access.sv
// Overview of operation
// - I/O space reads and writes complete in one clock cycle.
// - SRAM writes take one cycle; single SRAM reads return after two.
// - SRAM burst reads deliver a new word every cycle after the first.
// - EEPROM buffer load takes one cycle; single EEPROM read takes three.
// - EEPROM burst reads deliver a new byte every second cycle.
// - Four independent sections; masters on different sections never stall.
// - Flash write and erase act on whole pages; reads are byte-wide.
// - Flash word index is Z bits 8..1, page index Z bits 17..9.
// - Flash pages hold 256 words; 384 application plus 16 boot pages.
// - EEPROM write and erase by page or by byte; reads byte-wide.
// - EEPROM byte index is address bits 4..0, page bits 10..5.
`default_nettype none
module mem_access
   import mem_pkg::*;
(
   input wire logic sys_clk, // CPU clock
   input wire logic arst_n, // Async reset, low
   input wire logic [NUM_MASTERS-1:0] mReq, // Access request per master
   input wire logic [NUM_MASTERS-1:0] mWe, // 1 write, 0 read
   input wire logic [NUM_MASTERS-1:0] mBurst, // Burst read
   input wire logic [ADDR_W-1:0] mAddr [NUM_MASTERS], // Data address
   input wire logic [DATA_W-1:0] mWdata [NUM_MASTERS], // Write data
   output logic [NUM_MASTERS-1:0] mReady, // Request taken this cycle
   output logic [NUM_MASTERS-1:0] mWait, // Master must wait
   output logic [NUM_MASTERS-1:0] mRvalid, // Read data valid pulse
   output logic [DATA_W-1:0] mRdata [NUM_MASTERS], // Read data
   input wire logic [Z_W-1:0] zPointer, // Flash address pointer
   input wire logic flashPageCmd, // Flash page write/erase pulse
   output logic [7:0] flash_word_index, // Word within flash page
   output logic [8:0] flash_page_index, // Flash page number
   output logic flashPageValid, // Page index inside flash
   output logic flashCmdStrobe, // Page operation issued
   output logic [8:0] flashCmdPage, // Page of issued operation
   input wire logic [NVM_ADDR_W-1:0] nvmAddr, // NVM address register
   input wire logic eepromCmd, // EEPROM write/erase pulse
   input wire logic eepromPageMode, // 1 whole page, 0 one byte
   output logic [4:0] eeprom_byte_index, // Byte within EEPROM page
   output logic [5:0] eeprom_page_index, // EEPROM page number
   output logic eepromCmdStrobe, // EEPROM operation issued
   output logic eepromCmdPageMode, // Issued operation is page-wide
   output logic [5:0] eepromCmdPage, // Page of issued operation
   output logic [4:0] eepromCmdByte // Byte of issued operation
);
   sect_if sect [NUM_SECTIONS] ();

   logic [NUM_MASTERS-1:0] gnt [NUM_SECTIONS];
   logic [NUM_MASTERS-1:0] owner [NUM_SECTIONS];
   logic [NUM_MASTERS-1:0] unmapped;
   logic [NUM_MASTERS-1:0] unmappedRv;
   logic [NUM_SECTIONS-1:0] secAccept;
   logic [NUM_SECTIONS-1:0] secBusy;
   logic [NUM_SECTIONS-1:0] secRvalid;
   logic [DATA_W-1:0] secRdata [NUM_SECTIONS];

   function automatic logic isMapped(input logic [ADDR_W-1:0] a);
      return a < MAP_END;
   endfunction

   function automatic logic [1:0] sectionOf(input logic [ADDR_W-1:0] a);
      logic [1:0] s;
      s = 2'(SEC_IO);
      if (a >= SRAM1_BASE)
      begin
         s = 2'(SEC_SRAM1);
      end
      else if (a >= SRAM0_BASE)
      begin
         s = 2'(SEC_SRAM0);
      end
      else if (a >= EEPROM_BASE)
      begin
         s = 2'(SEC_EEPROM);
      end
      return s;
   endfunction

   function automatic logic hits(input logic [ADDR_W-1:0] a, input int s);
      return isMapped(a) && (sectionOf(a) == 2'(s));
   endfunction

   // Index widths follow the page geometry
   localparam int FLASH_WORD_INDEX_W = $clog2(FLASH_PAGE_WORDS);
   localparam int EBYTE_W = $clog2(EE_PAGE_BYTES);

   // Field decoders for the index and command paths
   function automatic logic [FLASH_WORD_INDEX_W-1:0] flashWordOf(
      input logic [Z_W-1:0] z);
      return z[FLASH_WORD_INDEX_MSB:FLASH_WORD_INDEX_LSB];
   endfunction

   function automatic logic [8:0] flashPageOf(
      input logic [Z_W-1:0] z);
      return z[FLASH_PAGE_INDEX_MSB:FLASH_PAGE_INDEX_LSB];
   endfunction

   function automatic logic flashPageOk(input logic [Z_W-1:0] z);
      return flashPageOf(z) < FLASH_PAGES;
   endfunction

   function automatic logic [EBYTE_W-1:0] eepromByteOf(
      input logic [NVM_ADDR_W-1:0] n);
      return n[EBYTE_MSB:EBYTE_LSB];
   endfunction

   function automatic logic [5:0] eepromPageOf(
      input logic [NVM_ADDR_W-1:0] n);
      return n[EPAGE_MSB:EPAGE_LSB];
   endfunction

   always_comb
   begin
      logic found;
      found = 1'b0;
      for (int s = 0; s < NUM_SECTIONS; s++)
      begin
         gnt[s] = '0;
         found = 1'b0;
         for (int m = 0; m < NUM_MASTERS; m++)
         begin
            if (!found && mReq[m] && hits(mAddr[m], s))
            begin
               gnt[s][m] = 1'b1;
               found = 1'b1;
            end
         end
      end
   end

   for (genvar s = 0; s < NUM_SECTIONS; s++)
   begin : g_sec
      always_comb
      begin
         logic [ADDR_W-1:0] a;
         a = '0;
         sect[s].we = 1'b0;
         sect[s].wdata = '0;
         for (int m = 0; m < NUM_MASTERS; m++)
         begin
            if (gnt[s][m])
            begin
               a = mAddr[m] - SEC_BASE[s];
               sect[s].we = mWe[m];
               sect[s].wdata = mWdata[m];
            end
         end
         sect[s].addr = a[LOCAL_W-1:0];
         sect[s].req = |gnt[s];
         sect[s].hold = |(owner[s] & mReq & mBurst & ~mWe);
      end

      assign secAccept[s] = sect[s].accept;
      assign secBusy[s] = sect[s].busy;
      assign secRvalid[s] = sect[s].rvalid;
      assign secRdata[s] = sect[s].rdata;

      // Owner steers read data back after the grant
      always_ff @(posedge sys_clk or negedge arst_n)
      begin
         if (!arst_n)
         begin
            owner[s] <= '0;
         end
         else if (sect[s].accept && !sect[s].we)
         begin
            owner[s] <= gnt[s];
         end
      end

      section_port #(
         .DEPTH_BITS(DEPTH_LOG[s]),
         .LAT(READ_LAT[s]),
         .GAP(BURST_GAP[s])
      ) u_port (
         .sys_clk(sys_clk),
         .arst_n(arst_n),
         .bus(sect[s])
      );
   end

   // Unmapped addresses answer at once, reads give zero
   always_comb
   begin
      for (int m = 0; m < NUM_MASTERS; m++)
      begin
         unmapped[m] = mReq[m] && !isMapped(mAddr[m]);
      end
   end

   always_ff @(posedge sys_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         unmappedRv <= '0;
      end
      else
      begin
         unmappedRv <= unmapped & ~mWe;
      end
   end

   always_comb
   begin
      for (int m = 0; m < NUM_MASTERS; m++)
      begin
         mReady[m] = unmapped[m];
         mRvalid[m] = unmappedRv[m];
         mRdata[m] = '0;
         mWait[m] = 1'b0;
         for (int s = 0; s < NUM_SECTIONS; s++)
         begin
            if (gnt[s][m] && secAccept[s])
            begin
               mReady[m] = 1'b1;
            end
            if (owner[s][m] && secBusy[s])
            begin
               mWait[m] = 1'b1;
            end
            if (owner[s][m] && secRvalid[s])
            begin
               mRvalid[m] = 1'b1;
               mRdata[m] = secRdata[s];
            end
         end
         if (mReq[m] && !mReady[m])
         begin
            mWait[m] = 1'b1;
         end
      end
   end

   always_ff @(posedge sys_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         flash_word_index <= '0;
         flash_page_index <= '0;
         flashPageValid <= 1'b0;
      end
      else
      begin
         flash_word_index <= flashWordOf(zPointer);
         flash_page_index <= flashPageOf(zPointer);
         flashPageValid <= flashPageOk(zPointer);
      end
   end

   always_ff @(posedge sys_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         flashCmdStrobe <= 1'b0;
         flashCmdPage <= '0;
      end
      else
      begin
         flashCmdStrobe <= 1'b0;
         if (flashPageCmd && flashPageOk(zPointer))
         begin
            flashCmdStrobe <= 1'b1;
            flashCmdPage <= flashPageOf(zPointer);
         end
      end
   end

   always_ff @(posedge sys_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         eeprom_byte_index <= '0;
         eeprom_page_index <= '0;
         eepromCmdStrobe <= 1'b0;
         eepromCmdPageMode <= 1'b0;
         eepromCmdPage <= '0;
         eepromCmdByte <= '0;
      end
      else
      begin
         eeprom_byte_index <= eepromByteOf(nvmAddr);
         eeprom_page_index <= eepromPageOf(nvmAddr);
         eepromCmdStrobe <= eepromCmd;
         if (eepromCmd)
         begin
            eepromCmdPageMode <= eepromPageMode;
            eepromCmdPage <= eepromPageOf(nvmAddr);
            // Byte index is meaningless for a page-wide operation
            eepromCmdByte <= eepromPageMode ? 5'h00
                                            : eepromByteOf(nvmAddr);
         end
      end
   end
endmodule // mem_access
`default_nettype wire

// >>> sim/mem_access_properties.sv
`default_nettype none
module mem_access_properties
   import mem_pkg::*;
(
   input wire logic sys_clk, // clock
   input wire logic arst_n, // reset
   input wire logic [2:0] mReq, // req
   input wire logic [2:0] mWe, // write
   input wire logic [15:0] mAddr [3], // addr
   input wire logic [2:0] mReady, // taken
   input wire logic [2:0] mWait, // wait
   input wire logic [2:0] mRvalid, // valid
   input wire logic [17:0] zPointer, // pointer
   input wire logic flashPageCmd, // cmd
   input wire logic [7:0] flash_word_index, // word
   input wire logic [8:0] flash_page_index, // page
   input wire logic flashCmdStrobe, // issued
   input wire logic [10:0] nvmAddr, // addr
   input wire logic eepromCmd, // cmd
   input wire logic eepromPageMode, // mode
   input wire logic eepromCmdStrobe, // issued
   input wire logic eepromCmdPageMode, // mode
   input wire logic [5:0] eepromCmdPage, // page
   input wire logic [4:0] eepromCmdByte // byte
);
   timeunit 1ns;
   timeprecision 100ps;
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!arst_n);
   wire logic rd0 = mReq[0] & mReady[0] & ~mWe[0];
   // 0 io, 1 eeprom, 2 and 3 sram, 4 and up unmapped
   function automatic int sec(logic [15:0] a);
      return a[15:13] == 0 ? int'(a[12]) : int'(a[15:13]) + 1;
   endfunction
   property p_io;
      rd0 && sec(mAddr[0]) == 0 |=> mRvalid[0];
   endproperty
   a_io: assert property (p_io) else $error("io read late");
   property p_sram;
      rd0 && sec(mAddr[0]) inside {2, 3} |=> !mRvalid[0] ##1 mRvalid[0];
   endproperty
   a_sram: assert property (p_sram) else $error("sram lat");
   property p_ee;
      rd0 && sec(mAddr[0]) == 1 |=> !mRvalid[0] [*2] ##1 mRvalid[0];
   endproperty
   a_ee: assert property (p_ee) else $error("eeprom lat");
   property p_wait;
      rd0 && sec(mAddr[0]) == 1 |=> mWait[0] [*2];
   endproperty
   a_wait: assert property (p_wait) else $error("no wait");
   property p_prio;
      mReq[0] && mReq[1] && sec(mAddr[0]) == sec(mAddr[1])
         && sec(mAddr[0]) < 4 |-> !mReady[1];
   endproperty
   a_prio: assert property (p_prio) else $error("priority");
   property p_fidx;
      $past(arst_n) |-> flash_word_index == $past(zPointer[8:1])
         && flash_page_index == $past(zPointer[17:9]);
   endproperty
   a_fidx: assert property (p_fidx) else $error("flash index");
   property p_fcmd;
      flashPageCmd && $stable(zPointer)
         |=> flashCmdStrobe == ($past(zPointer[17:9]) < FLASH_PAGES);
   endproperty
   a_fcmd: assert property (p_fcmd) else $error("flash cmd");
   property p_ecmd;
      eepromCmd && $stable(nvmAddr) |=> eepromCmdStrobe
         && eepromCmdPageMode == $past(eepromPageMode)
         && eepromCmdPage == $past(nvmAddr[10:5])
         && eepromCmdByte == ($past(eepromPageMode) ? 5'h0
            : $past(nvmAddr[4:0]));
   endproperty
   a_ecmd: assert property (p_ecmd) else $error("eeprom cmd");
endmodule // mem_access_properties
`default_nettype wire

// >>> sim/master_bfm.sv
`default_nettype none
module master_bfm
(
   input wire logic sys_clk, // clock
   input wire logic ready, // taken
   input wire logic rvalid, // valid
   input wire logic [7:0] rdata, // data
   output var logic req, // request
   output var logic we, // write
   output var logic burst, // burst
   output var logic [15:0] addr, // address
   output var logic [7:0] wdata // data
);
   timeunit 1ns;
   timeprecision 100ps;
   int lat;
   realtime tk;
   logic [7:0] got;
   logic [7:0] bq[$];
   int gq[$];
   initial
   begin
      req = 0;
      we = 0;
      burst = 0;
      addr = 0;
      wdata = 0;
   end
   // Ready is combinational: look late in the cycle
   task automatic wt();
      for (int i = 0; i < 40; i++)
      begin
         #2;
         if (ready === 1'b1)
            break;
         @(negedge sys_clk);
      end
      @(posedge sys_clk);
      tk = $realtime;
   endtask
   task automatic access(input logic w, input logic [15:0] a,
                         input logic [7:0] d);
      @(negedge sys_clk);
      req = 1;
      we = w;
      burst = 0;
      addr = a;
      wdata = d;
      wt();
      lat = 0;
      got = 'x;
      for (int i = 1; i < 6 && lat == 0; i++)
      begin
         @(negedge sys_clk);
         req = 0;
         addr = ~a;
         if (!w && rvalid === 1'b1)
         begin
            lat = i;
            got = rdata;
         end
      end
   endtask
   task automatic rd_burst(input logic [15:0] a, input int n);
      int c;
      int last;
      bq = {};
      gq = {};
      @(negedge sys_clk);
      req = 1;
      we = 0;
      burst = 1;
      addr = a;
      wt();
      c = 0;
      last = 0;
      while (bq.size() < n && c < 40)
      begin
         @(negedge sys_clk);
         c++;
         if (rvalid === 1'b1)
         begin
            bq.push_back(rdata);
            if (last > 0)
               gq.push_back(c - last);
            last = c;
         end
      end
      req = 0;
      burst = 0;
      // Drain the byte already due
      repeat (4) @(negedge sys_clk);
   endtask
endmodule // master_bfm
`default_nettype wire

// >>> sim/mem_access_tb.sv
`default_nettype none
module mem_access_tb
   import mem_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;
   logic sys_clk, arst_n, flashPageCmd, eepromCmd, eepromPageMode;
   logic [17:0] zPointer;
   logic [10:0] nvmAddr;
   wire logic [2:0] mReq, mWe, mBurst;
   wire logic [15:0] mAddr [3];
   wire logic [7:0] mWdata [3];
   logic [2:0] mReady, mWait, mRvalid;
   logic [7:0] mRdata [3];
   logic [7:0] flash_word_index;
   logic [8:0] flash_page_index, flashCmdPage;
   logic flashPageValid, flashCmdStrobe, eepromCmdStrobe;
   logic eepromCmdPageMode;
   logic [4:0] eeprom_byte_index, eepromCmdByte;
   logic [5:0] eeprom_page_index, eepromCmdPage;
   int nMismatch = 0;
   int checkCount = 0;
   int seed = 32'h8de7;
   logic [15:0] a;
   logic [7:0] d;
   logic [15:0] base [5] =
      '{16'h0000, 16'h1000, 16'h2000, 16'h4000, 16'h6000};
   int pg [3] = '{0, 399, 400};
   mem_access dut_u (.*);
   for (genvar i = 0; i < 3; i++)
   begin : m
      master_bfm u (.sys_clk(sys_clk), .ready(mReady[i]),
         .rvalid(mRvalid[i]), .rdata(mRdata[i]), .req(mReq[i]),
         .we(mWe[i]), .burst(mBurst[i]), .addr(mAddr[i]),
         .wdata(mWdata[i]));
   end
   initial
   begin
      sys_clk = 0;
      forever #2.5 sys_clk = ~sys_clk;
   end
   initial
   begin
      #50us;
      nMismatch++;
      endSim();
   end
   task automatic ck(input logic ok, input string s);
      checkCount++;
      if (ok !== 1'b1)
      begin
         $display("BAD %0t %s", $time, s);
         nMismatch++;
      end
   endtask
   function automatic int elat(logic [15:0] x);
      return x < 16'h1000 ? 1 : x < 16'h2000 ? 3 : x < 16'h6000 ? 2 : 1;
   endfunction
   task automatic endSim();
      if (nMismatch == 0 && checkCount > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   initial
   begin
      arst_n = 0;
      zPointer = 0;
      nvmAddr = 0;
      flashPageCmd = 0;
      eepromCmd = 0;
      eepromPageMode = 0;
      repeat (2) @(posedge sys_clk);
      @(negedge sys_clk);
      arst_n = 1;
      repeat (3)
         foreach (base[i])
         begin
            a = base[i] | (16'($random(seed)) & 16'h07ff);
            d = 8'($random(seed));
            m[0].u.access(1, a, d);
            m[0].u.access(0, a, d);
            ck(m[0].u.got === (a >= 16'h6000 ? 8'h00 : d), "data");
            ck(m[0].u.lat == elat(a), "read latency");
         end
      fork
         m[0].u.access(0, 16'h0010, 8'h00);
         m[1].u.access(1, 16'h2100, 8'h5a);
         m[2].u.access(0, 16'h4100, 8'h00);
      join
      ck(m[0].u.tk == m[1].u.tk && m[1].u.tk == m[2].u.tk, "par");
      fork
         m[0].u.access(1, 16'h2200, 8'h11);
         m[1].u.access(1, 16'h2201, 8'h22);
      join
      ck(m[1].u.tk - m[0].u.tk == 5.0, "same section");
      for (int k = 1; k < 4; k += 2)
      begin
         for (int j = 0; j < 4; j++)
            m[1].u.access(1, base[k] + 16'(j), 8'(j * 37 + k));
         m[2].u.rd_burst(base[k], 4);
         ck(m[2].u.bq.size() == 4, "burst count");
         for (int j = 0; j < m[2].u.bq.size(); j++)
            ck(m[2].u.bq[j] === 8'(j * 37 + k), "burst data");
         for (int j = 0; j < m[2].u.gq.size(); j++)
            ck(m[2].u.gq[j] == (k == 1 ? 2 : 1), "burst gap");
      end
      repeat (20)
      begin
         @(negedge sys_clk);
         zPointer = 18'($random(seed));
         nvmAddr = 11'($random(seed));
         @(negedge sys_clk);
         ck(flash_word_index === zPointer[8:1]
            && flash_page_index === zPointer[17:9], "flash idx");
         ck(flashPageValid === (zPointer[17:9] < 9'd400), "range");
         ck(eeprom_byte_index === nvmAddr[4:0]
            && eeprom_page_index === nvmAddr[10:5], "ee idx");
      end
      foreach (pg[i])
      begin
         zPointer = {9'(pg[i]), 9'($random(seed))};
         @(negedge sys_clk);
         flashPageCmd = 1;
         @(negedge sys_clk);
         flashPageCmd = 0;
         ck(flashCmdStrobe === (pg[i] < APP_PAGES + BOOT_PAGES)
            && (pg[i] >= 400 || flashCmdPage === 9'(pg[i])), "fc");
      end
      for (int k = 0; k < 2; k++)
      begin
         eepromPageMode = 1'(k);
         eepromCmd = 1;
         @(negedge sys_clk);
         eepromCmd = 0;
         ck(eepromCmdStrobe === 1'b1 && eepromCmdPageMode === 1'(k)
            && eepromCmdPage === nvmAddr[10:5]
            && eepromCmdByte === (k ? 5'h0 : nvmAddr[4:0]), "ec");
         @(negedge sys_clk);
      end
      endSim();
   end
endmodule // mem_access_tb
bind mem_access mem_access_properties chk_u (.*);
`default_nettype wire
